/* verilog/tccu_unit.sv */
// Timer capture/compare unit top level
`default_nettype none
module tccu_unit
  import tccu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] timer_count_i,
  input  wire logic [3:0]  unit_mode_field_i,
  input  wire logic        ctrl_wr_i,
  input  wire logic        flag_clr_i,
  input  wire logic        hold_wr_i,
  input  wire logic        hold_wr_high_i,
  input  wire logic [7:0]  hold_wr_data_i,
  input  wire logic        shared_event_pin_i,
  output logic [7:0]       hold_reg_high_o,
  output logic [7:0]       hold_reg_low_o,
  output logic             unit_irq_flag_o,
  output logic             cmp_latch_o,
  output logic             event_pulse_o
);
  tccu_state_type   state;
  tccu_state_type   next_state;
  tccu_kind_type    kind;
  tccu_hold_wr_type hwr;
  logic             cap_event;
  logic [3:0]       next_prescale;
  logic             match;

  function automatic tccu_kind_type mode_kind(input logic [3:0] m);
    case (m)
      MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16:
        mode_kind = KIND_CAP;
      MODE_CMP_HIGH, MODE_CMP_LOW, MODE_CMP_FLAG:
        mode_kind = KIND_CMP;
      default:
        mode_kind = KIND_OFF;
    endcase
  endfunction : mode_kind

  assign kind = mode_kind(unit_mode_field_i);
  assign hwr  = '{wr: hold_wr_i, wr_high: hold_wr_high_i,
                  data: hold_wr_data_i};
  assign match = (state.hold_reg == timer_count_i);

  // Pin sampled regardless of direction, so port writes can capture
  tccu_edge u_edge (
    .pin_now_i       (shared_event_pin_i),
    .pin_prev_i      (state.pin_prev),
    .mode_i          (unit_mode_field_i),
    .prescale_i      (state.prescale),
    .event_o         (cap_event),
    .next_prescale_o (next_prescale)
  );

  always_comb begin
    next_state            = state;
    next_state.pin_prev   = shared_event_pin_i;
    next_state.prescale   = next_prescale;
    next_state.flag_pulse = 1'b0;
    if (hwr.wr) begin
      if (hwr.wr_high) begin
        next_state.hold_reg[15:8] = hwr.data;
      end else begin
        next_state.hold_reg[7:0] = hwr.data;
      end
    end
    case (kind)
      KIND_CAP: begin
        if (cap_event) begin
          next_state.hold_reg   = timer_count_i;
          next_state.flag_pulse = 1'b1;
        end
      end
      KIND_CMP: begin
        if (match) begin
          next_state.flag_pulse = 1'b1;
          case (unit_mode_field_i)
            MODE_CMP_HIGH: begin
              next_state.cmp_latch = 1'b1;
            end
            MODE_CMP_LOW: begin
              next_state.cmp_latch = 1'b0;
            end
            default: begin
              next_state.cmp_latch = state.cmp_latch;
            end
          endcase
        end
      end
      KIND_OFF: begin
        next_state.prescale = PS_RESET;
      end
      default: begin
        next_state.prescale = PS_RESET;
      end
    endcase
    // Zero written to control drops the compare latch
    if (ctrl_wr_i && unit_mode_field_i == MODE_OFF) begin
      next_state.cmp_latch = 1'b0;
    end
    // Set beats clear so no event is lost
    if (flag_clr_i) begin
      next_state.irq_flag = 1'b0;
    end
    if (next_state.flag_pulse) begin
      next_state.irq_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '{hold_reg: HOLD_RESET, prescale: PS_RESET, pin_prev: 1'b0,
                 cmp_latch: 1'b0, irq_flag: 1'b0, flag_pulse: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign hold_reg_high_o = state.hold_reg[15:8];
  assign hold_reg_low_o  = state.hold_reg[7:0];
  assign unit_irq_flag_o = state.irq_flag;
  assign cmp_latch_o     = state.cmp_latch;
  assign event_pulse_o   = state.flag_pulse;

  sequence s_rise;
    !state.pin_prev ##1 state.pin_prev;
  endsequence

  a_capture_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (kind == KIND_CAP && cap_event) |=>
      state.hold_reg == $past(timer_count_i))
    else $error("capture did not store timer count");

  a_rise_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_RISE && shared_event_pin_i
     && !state.pin_prev) |=> event_pulse_o)
    else $error("rising edge missed");

  a_fall_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_RISE && !shared_event_pin_i
     && state.pin_prev && !match) |=> !event_pulse_o)
    else $error("falling edge captured in rising mode");

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_irq_flag_o && !flag_clr_i) |=> unit_irq_flag_o)
    else $error("flag dropped without clear");

  a_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    event_pulse_o |-> unit_irq_flag_o)
    else $error("event without flag");

  a_prescale_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (kind != KIND_CAP) |=> state.prescale == PS_RESET)
    else $error("prescaler not cleared");

  a_by_four: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_RISE4 && shared_event_pin_i
     && !state.pin_prev && state.prescale[1:0] != PS_LAST_4[1:0])
    |=> !event_pulse_o)
    else $error("divide-by-four captured early");

  a_cmp_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CMP_HIGH && match && !ctrl_wr_i)
    |=> cmp_latch_o && unit_irq_flag_o)
    else $error("compare high not driven");

  a_cmp_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CMP_FLAG && !ctrl_wr_i)
    |=> cmp_latch_o == $past(cmp_latch_o))
    else $error("flag-only compare moved latch");

  a_zero_ctrl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_wr_i && unit_mode_field_i == MODE_OFF) |=> !cmp_latch_o)
    else $error("control clear left latch high");

  // Building blocks for the multi-step checks below
  sequence s_pin_up;
    shared_event_pin_i && !state.pin_prev;
  endsequence

  sequence s_pin_down;
    !shared_event_pin_i && state.pin_prev;
  endsequence

  sequence s_cap_pulse;
    event_pulse_o && unit_irq_flag_o;
  endsequence

  // Pin history follows the pin whatever its direction
  a_pin_sampled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_rise |-> $past(shared_event_pin_i))
    else $error("pin history lost a rise");

  a_fall_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_FALL) ##0 s_pin_down
    |=> s_cap_pulse)
    else $error("falling edge missed");

  a_rise_in_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_FALL) ##0 s_pin_up
    |=> !event_pulse_o)
    else $error("rising edge captured in falling mode");

  a_four_fire: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_RISE4) ##0 s_pin_up
    ##0 (state.prescale[1:0] == PS_LAST_4[1:0])
    |=> s_cap_pulse)
    else $error("divide-by-four capture missed");

  a_sixteen_early: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_RISE16) ##0 s_pin_up
    ##0 (state.prescale != PS_LAST_16)
    |=> !event_pulse_o)
    else $error("divide-by-sixteen captured early");

  a_sixteen_fire: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_RISE16) ##0 s_pin_up
    ##0 (state.prescale == PS_LAST_16)
    |=> s_cap_pulse)
    else $error("divide-by-sixteen capture missed");

  // The count carries over between prescale settings
  a_prescale_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CAP_RISE4
     || unit_mode_field_i == MODE_CAP_RISE16) ##0 s_pin_up
    |=> state.prescale == $past(state.prescale) + 4'h1)
    else $error("prescaler did not advance");

  a_hold_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!hold_wr_i && !(kind == KIND_CAP && cap_event))
    |=> $stable(state.hold_reg))
    else $error("holding register moved without cause");

  // Software byte writes land unless a capture takes the cycle
  a_hold_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (hold_wr_i && hold_wr_high_i && !(kind == KIND_CAP && cap_event))
    |=> hold_reg_high_o == $past(hold_wr_data_i))
    else $error("high byte write lost");

  a_hold_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (hold_wr_i && !hold_wr_high_i && !(kind == KIND_CAP && cap_event))
    |=> hold_reg_low_o == $past(hold_wr_data_i))
    else $error("low byte write lost");

  a_cmp_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (unit_mode_field_i == MODE_CMP_LOW && match && !ctrl_wr_i)
    |=> !cmp_latch_o && unit_irq_flag_o)
    else $error("compare low not driven");

  a_cmp_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (kind == KIND_CMP && match) |=> s_cap_pulse)
    else $error("compare match without flag");

  a_cmp_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (kind == KIND_CMP && !match) |=> !event_pulse_o)
    else $error("compare pulse without match");

  a_off_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (kind == KIND_OFF) |=> !event_pulse_o)
    else $error("event raised while off");

  // Capture modes never touch the compare latch
  a_latch_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (kind == KIND_CAP) |=> $stable(cmp_latch_o))
    else $error("compare latch moved in capture mode");

  a_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (flag_clr_i && !next_state.flag_pulse) |=> !unit_irq_flag_o)
    else $error("flag clear ignored");

  a_flag_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (flag_clr_i && next_state.flag_pulse) |=> unit_irq_flag_o)
    else $error("clear beat a new event");
endmodule : tccu_unit
`default_nettype wire

/* verilog/tccu_pkg.sv */
// Package of constants and types for the timer capture/compare unit
`default_nettype none
package tccu_pkg;
  localparam int TIMER_WIDTH = 16;
  localparam int MODE_WIDTH  = 4;
  localparam int PS_WIDTH    = 4;
  localparam int FLAG_BIT    = 2;
  localparam int DIR_BIT     = 3;

  // Mode codes of unit_mode_field
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH   = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW    = 4'h9;
  localparam logic [3:0] MODE_CMP_FLAG   = 4'hA;

  localparam logic [3:0]  PS_RESET      = 4'h0;
  localparam logic [3:0]  PS_LAST_4     = 4'h3;
  localparam logic [3:0]  PS_LAST_16    = 4'hF;
  localparam logic [15:0] HOLD_RESET    = 16'h0000;

  typedef enum logic [2:0] {
    KIND_OFF = 3'b001,
    KIND_CAP = 3'b010,
    KIND_CMP = 3'b100
  } tccu_kind_type;

  typedef struct packed {
    logic [15:0] hold_reg;
    logic [3:0]  prescale;
    logic        pin_prev;
    logic        cmp_latch;
    logic        irq_flag;
    logic        flag_pulse;
  } tccu_state_type;

  typedef struct packed {
    logic        wr;
    logic        wr_high;
    logic [7:0]  data;
  } tccu_hold_wr_type;
endpackage : tccu_pkg
`default_nettype wire

/* verilog/tccu_edge.sv */
// Capture event qualifier: edge choice and event prescaler
`default_nettype none
module tccu_edge
  import tccu_pkg::*;
(
  input  wire logic       pin_now_i,
  input  wire logic       pin_prev_i,
  input  wire logic [3:0] mode_i,
  input  wire logic [3:0] prescale_i,
  output logic            event_o,
  output logic [3:0]      next_prescale_o
);
  logic rise;
  logic fall;

  always_comb begin
    rise            = pin_now_i & ~pin_prev_i;
    fall            = ~pin_now_i & pin_prev_i;
    event_o         = 1'b0;
    next_prescale_o = prescale_i;
    case (mode_i)
      MODE_CAP_FALL: begin
        event_o = fall;
      end
      MODE_CAP_RISE: begin
        event_o = rise;
      end
      MODE_CAP_RISE4: begin
        // Counter kept across prescale switches
        if (rise) begin
          event_o         = (prescale_i[1:0] == PS_LAST_4[1:0]);
          next_prescale_o = prescale_i + 4'h1;
        end
      end
      MODE_CAP_RISE16: begin
        if (rise) begin
          event_o         = (prescale_i == PS_LAST_16);
          next_prescale_o = prescale_i + 4'h1;
        end
      end
      default: begin
        next_prescale_o = PS_RESET;
      end
    endcase
  end
endmodule : tccu_edge
`default_nettype wire

/* bench/tccu_pin_model.sv */
// Partner model of the shared event pin: outside source or own latch
`default_nettype none
module tccu_pin_model
  import tccu_pkg::*;
(
  input  wire logic dir_input_i,
  input  wire logic drive_level_i,
  input  wire logic cmp_latch_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // As output the pin carries the latch, so the unit sees its own drive
  assign pin_o = dir_input_i ? drive_level_i : cmp_latch_i;
endmodule : tccu_pin_model
`default_nettype wire

/* bench/timer_capture_compare_unit_bench.sv */
// Self-checking bench of the timer capture/compare unit
`default_nettype none
module timer_capture_compare_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tccu_pkg::*;
  logic        clk_i = 0, rst_n_i = 0, ctrl_wr = 0, flag_clr = 0;
  logic        hold_wr = 0, wr_high = 0, dir_in = 1, lvl = 0;
  logic [15:0] timer = 16'h0000, t, h;
  logic [3:0]  mode = MODE_OFF, ps, m;
  logic [7:0]  wr_data = 8'h00, hi, lo;
  logic        flag, latch, pulse, pin, f;
  int          n_errors = 0, checked = 0;
  logic [3:0]  pm [2] = '{MODE_CAP_RISE4, MODE_CAP_RISE16};
  logic [3:0]  cm [5] = '{MODE_CMP_HIGH, MODE_CMP_FLAG, MODE_CMP_LOW,
                          MODE_CMP_FLAG, MODE_CMP_HIGH};
  logic        ce [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  always #5 clk_i = ~clk_i;

  tccu_unit dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .timer_count_i(timer),
    .unit_mode_field_i(mode), .ctrl_wr_i(ctrl_wr), .flag_clr_i(flag_clr),
    .hold_wr_i(hold_wr), .hold_wr_high_i(wr_high),
    .hold_wr_data_i(wr_data), .shared_event_pin_i(pin),
    .hold_reg_high_o(hi), .hold_reg_low_o(lo), .unit_irq_flag_o(flag),
    .cmp_latch_o(latch), .event_pulse_o(pulse));
  tccu_pin_model partner (.dir_input_i(dir_in), .drive_level_i(lvl),
    .cmp_latch_i(latch), .pin_o(pin));

  task automatic results;
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic set_mode(input logic [3:0] m);
    @(posedge clk_i);
    mode <= m;
    ctrl_wr <= 1'b1;
    @(posedge clk_i);
    ctrl_wr <= 1'b0;
  endtask : set_mode

  task automatic pin_to(input logic v);
    @(posedge clk_i);
    lvl <= v;
  endtask : pin_to

  // Mode changes may leave a stale flag, so software clears it
  task automatic clr_flag;
    @(posedge clk_i);
    flag_clr <= 1'b1;
    @(posedge clk_i);
    flag_clr <= 1'b0;
    #1;
    chk(flag, 1'b0);
  endtask : clr_flag

  // Prescaled capture fires on the count value before increment
  function automatic logic fire(input logic [3:0] m, input logic [3:0] c);
    return (m == MODE_CAP_RISE4) ? (c[1:0] == 2'h3) : (c == 4'hF);
  endfunction : fire

  initial begin
    void'($urandom(74750));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(1);
    chk({hi, lo}, HOLD_RESET);
    chk({flag, latch, pulse}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      m = k[0] ? MODE_CAP_RISE : MODE_CAP_FALL;
      pin_to(m == MODE_CAP_FALL);
      set_mode(m);
      clr_flag();
      t = 16'($urandom);
      @(posedge clk_i);
      timer <= t;
      pin_to(m != MODE_CAP_FALL);
      tick(2);
      chk({hi, lo}, t);
      chk(flag, 1'b1);
    end
    pin_to(1'b0);
    set_mode(MODE_OFF);
    ps = 4'h0;
    h = {hi, lo};
    foreach (pm[j]) begin
      set_mode(pm[j]);
      clr_flag();
      for (int n = 0; n < 18; n++) begin
        t = 16'($urandom);
        @(posedge clk_i);
        timer <= t;
        pin_to(1'b1);
        tick(2);
        f = fire(pm[j], ps);
        ps = ps + 4'h1;
        if (f) h = t;
        chk({hi, lo}, h);
        chk(flag, f);
        if (f) clr_flag();
        pin_to(1'b0);
      end
    end
    set_mode(MODE_OFF);
    h = 16'($urandom);
    @(posedge clk_i);
    hold_wr <= 1'b1;
    wr_high <= 1'b1;
    wr_data <= h[15:8];
    @(posedge clk_i);
    wr_high <= 1'b0;
    wr_data <= h[7:0];
    @(posedge clk_i);
    hold_wr <= 1'b0;
    timer <= h + 16'h0001;
    dir_in <= 1'b0;
    tick(1);
    chk({hi, lo}, h);
    foreach (cm[j]) begin
      set_mode(cm[j]);
      clr_flag();
      @(posedge clk_i);
      timer <= h;
      tick(1);
      chk(latch, ce[j]);
      chk({flag, pulse}, 16'h0003);
      chk(pin, ce[j]);
      @(posedge clk_i);
      timer <= h + 16'h0001;
    end
    set_mode(MODE_OFF);
    tick(0);
    chk(latch, 1'b0);
    results();
  end

  // Tests need well under 2000 cycles
  initial begin
    #200000;
    n_errors++;
    results();
  end
endmodule : timer_capture_compare_unit_bench
`default_nettype wire
